// [rtl/deframer_pkg.sv]
// Register map, field positions, reset values and control characters of the deframer slice.
package deframer_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [11:0] IDX_CHECKSUM   = 12'h472;
  localparam logic [11:0] IDX_LANE_SYNC  = 12'h473;
  localparam logic [11:0] IDX_CTRL0      = 12'h475;
  localparam logic [11:0] IDX_CTRL1      = 12'h476;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h480;
  localparam logic [11:0] IDX_IRQ_MASK   = 12'h481;

  // Field positions of the first control register.
  localparam int unsigned CTRL0_RECEIVER_DISABLE_BIT     = 7;
  localparam int unsigned CTRL0_SUBST_DIS_BIT  = 6;
  localparam int unsigned CTRL0_SOFT_RST_BIT   = 3;
  localparam int unsigned CTRL0_FORCE_SYNC_BIT = 2;
  localparam int unsigned CTRL0_REPL_FRM_BIT   = 0;

  // Field position of the second control register.
  localparam int unsigned CTRL1_SKIP_ALIGN_BIT = 1;

  // Values after reset.
  localparam logic [7:0] CTRL0_RESET      = 8'h01;
  localparam logic [7:0] CTRL1_RESET      = 8'h00;
  localparam logic [7:0] LANE_FLAGS_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET        = 8'h00;

  // Control characters that close a frame and a multiframe.
  localparam logic [7:0] FRAME_END_CHAR      = 8'hfc;
  localparam logic [7:0] MULTIFRAME_END_CHAR = 8'h7c;

endpackage

// [rtl/lane_status_capture.sv]
// Per-lane capture of alignment sync and checksum flags with loss-of-sync events.
`timescale 1ns/1ns

module lane_status_capture #(
  parameter int unsigned LANES = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic [LANES-1:0] synced_in,
  input  wire logic [LANES-1:0] checksum_in,
  output logic      [LANES-1:0] synced_q,
  output logic      [LANES-1:0] checksum_q,
  output logic      [LANES-1:0] sync_lost
);

  typedef struct packed {
    logic [LANES-1:0] synced;
    logic [LANES-1:0] checksum;
    logic [LANES-1:0] lost;
  } state_s;

  state_s           state_q;
  state_s           state_d;
  logic [LANES-1:0] lost_now;

  initial begin
    if (LANES < 1 || LANES > 8) begin
      $error("lane_status_capture supports one to eight lanes.");
    end
  end

  // A lane reports a loss when its captured sync flag falls.
  generate
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign lost_now[l] = state_q.synced[l] & ~synced_in[l];
    end
  endgenerate

  // The soft reset returns every flag to its power-on value.
  always_comb begin
    state_d = state_q;
    if (clear) begin
      state_d = '0;
    end else begin
      state_d.synced   = synced_in;
      state_d.checksum = checksum_in;
      state_d.lost     = lost_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign synced_q   = state_q.synced;
  assign checksum_q = state_q.checksum;
  assign sync_lost  = state_q.lost;

endmodule

// [rtl/char_substitute.sv]
// Replacement of end-of-frame and end-of-multiframe control characters on one lane.
`timescale 1ns/1ns

module char_substitute (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       rx_enable,
  input  wire logic       subst_disable,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_octet,
  input  wire logic       in_is_ctrl,
  input  wire logic       in_frame_end,
  input  wire logic       in_multiframe_end,
  output logic            out_valid,
  output logic      [7:0] out_octet,
  output logic            out_is_ctrl
);

  typedef struct packed {
    logic       valid;
    logic [7:0] octet;
    logic       is_ctrl;
    logic [7:0] last_octet;
  } state_s;

  state_s state_q;
  state_s state_d;
  logic   hit;

  // A closing character sits in the last octet of a frame or multiframe.
  assign hit = in_is_ctrl &&
               ((in_frame_end && in_octet == deframer_pkg::FRAME_END_CHAR) ||
                (in_multiframe_end && in_octet == deframer_pkg::MULTIFRAME_END_CHAR));

  // The substitute is the final octet of the previous frame.
  always_comb begin
    state_d       = state_q;
    state_d.valid = 1'b0;
    if (clear) begin
      state_d = '0;
    end else if (rx_enable && in_valid) begin
      state_d.valid   = 1'b1;
      state_d.octet   = in_octet;
      state_d.is_ctrl = in_is_ctrl;
      if (hit && !subst_disable) begin
        state_d.octet   = state_q.last_octet;
        state_d.is_ctrl = 1'b0;
      end
      if (in_frame_end) begin
        state_d.last_octet = state_d.octet;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign out_valid   = state_q.valid;
  assign out_octet   = state_q.octet;
  assign out_is_ctrl = state_q.is_ctrl;

endmodule

// [rtl/deframer_lane_sync_status_ctrl.sv]
// APB register slice for deframer lane sync status, control bits and lane-0 substitution.
//
// Behaviour
// - Lane 0 checksum flag reads 1 on match, 0 otherwise, cleared at reset.
// - Eight-bit read-only register, bit n is lane n alignment sync, cleared at reset.
// - Receiver-disable bit 7 at 1 blocks reception; at 0 reception is allowed.
// - Substitution-disable at 1 keeps closing characters; at 0 they are substituted.
// - Soft reset bit synchronously restores deframer logic and blocks reception.
// - Skip option with one lane omits the alignment sequence after code group sync.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ns

module deframer_lane_sync_status_ctrl #(
  parameter int unsigned LANES  = 8,
  parameter int unsigned ADDR_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [LANES-1:0]  lane_alignment_synced,
  input  wire logic [LANES-1:0]  lane_checksum_ok,
  input  wire logic              single_lane_mode,
  input  wire logic              lane0_valid,
  input  wire logic [7:0]        lane0_octet,
  input  wire logic              lane0_is_ctrl,
  input  wire logic              lane0_frame_end,
  input  wire logic              lane0_multiframe_end,
  output logic                   out_valid,
  output logic      [7:0]        out_octet,
  output logic                   out_is_ctrl,
  output logic                   rx_enable,
  output logic                   deframer_soft_reset,
  output logic                   force_sync_request,
  output logic                   frame_error_replace_enable,
  output logic                   alignment_seq_expected,
  output logic                   irq
);

  typedef struct packed {
    logic             receiver_disable;
    logic             char_substitution_disable;
    logic             soft_reset;
    logic             force_sync;
    logic             replace_frames;
    logic             skip_alignment_sequence;
    logic [LANES-1:0] irq_status;
    logic [LANES-1:0] irq_mask;
    logic [31:0]      rdata;
    logic             err;
    logic             rx_enable;
    logic             align_expected;
    logic             irq;
  } state_s;

  state_s           state_q;
  state_s           state_d;
  logic [LANES-1:0] lane_synced_q;
  logic [LANES-1:0] lane_checksum_q;
  logic [LANES-1:0] sync_lost;
  logic [11:0]      reg_idx;
  logic             addr_ok;
  logic             setup;
  logic             access;
  logic             wr_en;
  logic [7:0]       wbyte;
  logic [7:0]       lane_sync_reg;
  logic [7:0]       checksum_reg;
  logic [7:0]       irq_status_reg;
  logic [7:0]       irq_mask_reg;
  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;

  initial begin
    if (LANES < 1 || LANES > 8) begin
      $error("deframer_lane_sync_status_ctrl supports one to eight lanes.");
    end
    if (ADDR_W < 14 || ADDR_W > 32) begin
      $error("deframer_lane_sync_status_ctrl needs 14 to 32 address bits.");
    end
  end

  // Lane flags are captured each cycle and cleared by the soft reset.
  lane_status_capture #(
    .LANES (LANES)
  ) u_status (
    .pclk        (pclk),
    .presetn     (presetn),
    .clear       (state_q.soft_reset),
    .synced_in   (lane_alignment_synced),
    .checksum_in (lane_checksum_ok),
    .synced_q    (lane_synced_q),
    .checksum_q  (lane_checksum_q),
    .sync_lost   (sync_lost)
  );

  // Lane 0 octet path with closing character substitution.
  char_substitute u_subst (
    .pclk              (pclk),
    .presetn           (presetn),
    .clear             (state_q.soft_reset),
    .rx_enable         (state_q.rx_enable),
    .subst_disable     (state_q.char_substitution_disable),
    .in_valid          (lane0_valid),
    .in_octet          (lane0_octet),
    .in_is_ctrl        (lane0_is_ctrl),
    .in_frame_end      (lane0_frame_end),
    .in_multiframe_end (lane0_multiframe_end),
    .out_valid         (out_valid),
    .out_octet         (out_octet),
    .out_is_ctrl       (out_is_ctrl)
  );

  // Address decode: word aligned, index in bits 13 to 2, upper bits zero.
  assign reg_idx = paddr[13:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr >> 14) == '0 &&
                   (reg_idx == deframer_pkg::IDX_CHECKSUM ||
                    reg_idx == deframer_pkg::IDX_LANE_SYNC ||
                    reg_idx == deframer_pkg::IDX_CTRL0 ||
                    reg_idx == deframer_pkg::IDX_CTRL1 ||
                    reg_idx == deframer_pkg::IDX_IRQ_STATUS ||
                    reg_idx == deframer_pkg::IDX_IRQ_MASK);
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_en   = access && pwrite && !state_q.err && pstrb[0];
  assign wbyte   = pwdata[7:0];

  // Register views, narrow fields padded to eight bits with zeros.
  always_comb begin
    lane_sync_reg  = '0;
    checksum_reg   = '0;
    irq_status_reg = '0;
    irq_mask_reg   = '0;
    lane_sync_reg[LANES-1:0]  = lane_synced_q;
    checksum_reg[LANES-1:0]   = lane_checksum_q;
    irq_status_reg[LANES-1:0] = state_q.irq_status;
    irq_mask_reg[LANES-1:0]   = state_q.irq_mask;
    ctrl0_reg = '0;
    ctrl0_reg[deframer_pkg::CTRL0_RECEIVER_DISABLE_BIT]     = state_q.receiver_disable;
    ctrl0_reg[deframer_pkg::CTRL0_SUBST_DIS_BIT]  = state_q.char_substitution_disable;
    ctrl0_reg[deframer_pkg::CTRL0_SOFT_RST_BIT]   = state_q.soft_reset;
    ctrl0_reg[deframer_pkg::CTRL0_FORCE_SYNC_BIT] = state_q.force_sync;
    ctrl0_reg[deframer_pkg::CTRL0_REPL_FRM_BIT]   = state_q.replace_frames;
    ctrl1_reg = '0;
    ctrl1_reg[deframer_pkg::CTRL1_SKIP_ALIGN_BIT] = state_q.skip_alignment_sequence;
  end

  // Next state: read data at setup, writes at the access edge, sticky events.
  always_comb begin
    state_d = state_q;
    if (setup) begin
      state_d.err   = !addr_ok;
      state_d.rdata = '0;
      if (addr_ok && !pwrite) begin
        unique case (reg_idx)
          deframer_pkg::IDX_CHECKSUM:   state_d.rdata = {24'h000000, checksum_reg};
          deframer_pkg::IDX_LANE_SYNC:  state_d.rdata = {24'h000000, lane_sync_reg};
          deframer_pkg::IDX_CTRL0:      state_d.rdata = {24'h000000, ctrl0_reg};
          deframer_pkg::IDX_CTRL1:      state_d.rdata = {24'h000000, ctrl1_reg};
          deframer_pkg::IDX_IRQ_STATUS: state_d.rdata = {24'h000000, irq_status_reg};
          deframer_pkg::IDX_IRQ_MASK:   state_d.rdata = {24'h000000, irq_mask_reg};
          default:                      state_d.rdata = '0;
        endcase
      end
    end
    if (wr_en) begin
      // The lane sync and checksum registers have no write case.
      unique case (reg_idx)
        deframer_pkg::IDX_CTRL0: begin
          state_d.receiver_disable = wbyte[deframer_pkg::CTRL0_RECEIVER_DISABLE_BIT];
          state_d.char_substitution_disable = wbyte[deframer_pkg::CTRL0_SUBST_DIS_BIT];
          state_d.soft_reset     = wbyte[deframer_pkg::CTRL0_SOFT_RST_BIT];
          state_d.force_sync     = wbyte[deframer_pkg::CTRL0_FORCE_SYNC_BIT];
          state_d.replace_frames = wbyte[deframer_pkg::CTRL0_REPL_FRM_BIT];
        end
        deframer_pkg::IDX_CTRL1: begin
          state_d.skip_alignment_sequence = wbyte[deframer_pkg::CTRL1_SKIP_ALIGN_BIT];
        end
        deframer_pkg::IDX_IRQ_STATUS: begin
          state_d.irq_status = state_q.irq_status & ~wbyte[LANES-1:0];
        end
        deframer_pkg::IDX_IRQ_MASK: begin
          state_d.irq_mask = wbyte[LANES-1:0];
        end
        default: begin
          state_d.err = state_q.err;
        end
      endcase
    end
    // A loss of sync in the clearing cycle still sets its bit.
    state_d.irq_status = state_d.irq_status | sync_lost;
    // Reception held off during soft reset.
    state_d.rx_enable = !state_d.receiver_disable && !state_d.soft_reset;
    // Alignment sequence omitted for one lane when the skip bit is set.
    state_d.align_expected = !(state_d.skip_alignment_sequence && single_lane_mode);
    state_d.irq = |(state_d.irq_status & state_d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q.receiver_disable          <= deframer_pkg::CTRL0_RESET[deframer_pkg::CTRL0_RECEIVER_DISABLE_BIT];
      state_q.char_substitution_disable <=
        deframer_pkg::CTRL0_RESET[deframer_pkg::CTRL0_SUBST_DIS_BIT];
      state_q.soft_reset     <= deframer_pkg::CTRL0_RESET[deframer_pkg::CTRL0_SOFT_RST_BIT];
      state_q.force_sync     <= deframer_pkg::CTRL0_RESET[deframer_pkg::CTRL0_FORCE_SYNC_BIT];
      state_q.replace_frames <= deframer_pkg::CTRL0_RESET[deframer_pkg::CTRL0_REPL_FRM_BIT];
      state_q.skip_alignment_sequence <=
        deframer_pkg::CTRL1_RESET[deframer_pkg::CTRL1_SKIP_ALIGN_BIT];
      state_q.irq_status     <= deframer_pkg::IRQ_RESET[LANES-1:0];
      state_q.irq_mask       <= deframer_pkg::IRQ_RESET[LANES-1:0];
      state_q.rdata          <= '0;
      state_q.err            <= 1'b0;
      state_q.rx_enable      <= 1'b1;
      state_q.align_expected <= 1'b1;
      state_q.irq            <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // Zero-wait APB answer; data and error come from flip-flops.
  assign pready  = access;
  assign pslverr = access && state_q.err;
  assign prdata  = state_q.rdata;

  assign rx_enable                  = state_q.rx_enable;
  assign deframer_soft_reset        = state_q.soft_reset;
  assign force_sync_request         = state_q.force_sync;
  assign frame_error_replace_enable = state_q.replace_frames;
  assign alignment_seq_expected     = state_q.align_expected;
  assign irq                        = state_q.irq;

endmodule

// [test/deframer_lane_sync_status_ctrl_properties.sv]
// Port-level checker for the deframer register slice.
`timescale 1ns/1ns
module deframer_lane_sync_status_ctrl_properties #(
  parameter int unsigned LANES  = 8,
  parameter int unsigned ADDR_W = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic [LANES-1:0]  lane_alignment_synced,
  input wire logic [LANES-1:0]  lane_checksum_ok,
  input wire logic              single_lane_mode,
  input wire logic              lane0_valid,
  input wire logic [7:0]        lane0_octet,
  input wire logic              lane0_is_ctrl,
  input wire logic              lane0_frame_end,
  input wire logic              out_valid,
  input wire logic [7:0]        out_octet,
  input wire logic              out_is_ctrl,
  input wire logic              rx_enable,
  input wire logic              deframer_soft_reset,
  input wire logic              alignment_seq_expected
);
  localparam logic [ADDR_W-1:0] A_C0 = ADDR_W'({deframer_pkg::IDX_CTRL0, 2'b00});
  localparam logic [ADDR_W-1:0] A_C1 = ADDR_W'({deframer_pkg::IDX_CTRL1, 2'b00});
  localparam logic [ADDR_W-1:0] A_SY = ADDR_W'({deframer_pkg::IDX_LANE_SYNC, 2'b00});
  localparam logic [ADDR_W-1:0] A_CK = ADDR_W'({deframer_pkg::IDX_CHECKSUM, 2'b00});
  logic       wr;
  logic       rd_setup;
  logic       subst_dis_q;
  logic       skip_q;
  logic [1:0] up_q;
  // Write strobe and read setup seen on the bus.
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable && !pwrite && up_q == 2'h3;
  // Shadow copies of the substitution-disable and skip bits, and an edge count since reset that stops at 3.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subst_dis_q <= 1'b0;
      skip_q <= 1'b0;
      up_q <= 2'h0;
    end else begin
      if (wr && paddr == A_C0) subst_dis_q <= pwdata[6];
      if (wr && paddr == A_C1) skip_q <= pwdata[1];
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_soft_rst_blocks: assert property (wr && paddr == A_C0 && pwdata[3] |=>
    deframer_soft_reset && !rx_enable) else $error("soft reset left reception on");
  a_receiver_disable_off: assert property (wr && paddr == A_C0 && pwdata[7] |=> !rx_enable)
    else $error("receiver disable ignored");
  a_receiver_disable_on: assert property (wr && paddr == A_C0 && !pwdata[7] && !pwdata[3] |=>
    rx_enable) else $error("reception not permitted");
  a_no_rx_out: assert property (!rx_enable |=> !out_valid)
    else $error("octet out while disabled");
  a_subst_off_pass: assert property (subst_dis_q && rx_enable && lane0_valid |=>
    out_valid && out_octet == $past(lane0_octet) && out_is_ctrl == $past(lane0_is_ctrl))
    else $error("octet altered with substitution off");
  a_subst_on_repl: assert property (!subst_dis_q && rx_enable && lane0_valid &&
    lane0_is_ctrl && lane0_frame_end && lane0_octet == deframer_pkg::FRAME_END_CHAR
    |=> out_valid && !out_is_ctrl) else $error("frame end not substituted");
  a_sync_read_val: assert property (rd_setup && paddr == A_SY && !deframer_soft_reset &&
    !$past(deframer_soft_reset) |=> prdata == 32'($past(lane_alignment_synced, 2)))
    else $error("lane sync read wrong");
  a_cks_read_val: assert property (rd_setup && paddr == A_CK && !deframer_soft_reset &&
    !$past(deframer_soft_reset) |=> prdata[0] == $past(lane_checksum_ok[0], 2))
    else $error("lane 0 checksum read wrong");
  a_skip_align_off: assert property (skip_q && single_lane_mode ##1 skip_q &&
    single_lane_mode |-> !alignment_seq_expected) else $error("alignment still expected");
endmodule

bind deframer_lane_sync_status_ctrl deframer_lane_sync_status_ctrl_properties #(
  .LANES(LANES), .ADDR_W(ADDR_W)) props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .lane_alignment_synced, .lane_checksum_ok,
  .single_lane_mode, .lane0_valid, .lane0_octet, .lane0_is_ctrl, .lane0_frame_end,
  .out_valid, .out_octet, .out_is_ctrl, .rx_enable, .deframer_soft_reset,
  .alignment_seq_expected);

// [test/lane_tx_model.sv]
// Behavioural link transmitter that feeds lane flags and the lane 0 octet stream.
`timescale 1ns/1ns
module lane_tx_model (
  input  wire logic pclk,
  output logic       lane0_valid,
  output logic [7:0] lane0_octet,
  output logic       lane0_is_ctrl,
  output logic       lane0_frame_end,
  output logic       lane0_multiframe_end,
  output logic [7:0] lane_alignment_synced,
  output logic [7:0] lane_checksum_ok
);
  // Idle lines start in a known state.
  initial begin
    {lane0_valid, lane0_is_ctrl, lane0_frame_end, lane0_multiframe_end} = 4'h0;
    lane0_octet = 8'h5a;
    lane_alignment_synced = 8'h00;
    lane_checksum_ok = 8'h00;
  end
  // Lane flags change just after an edge.
  task automatic set_lanes(input logic [7:0] s, input logic [7:0] c);
    lane_alignment_synced <= s;
    lane_checksum_ok <= c;
  endtask
  // One frame of three data octets closed by a control character.
  task automatic send_frame(input logic [7:0] b, input logic mf);
    for (int i = 0; i < 4; i++) begin
      lane0_valid <= 1'b1;
      lane0_octet <= (i < 3) ? b + 8'(i) : (mf ? 8'h7c : 8'hfc);
      lane0_is_ctrl <= (i == 3);
      lane0_frame_end <= (i == 3);
      lane0_multiframe_end <= (i == 3) && mf;
      @(posedge pclk);
    end
    lane0_valid <= 1'b0;
    lane0_octet <= ~lane0_octet; // Released octet lines show the inverse.
    {lane0_is_ctrl, lane0_frame_end, lane0_multiframe_end} <= 3'h0;
  endtask
  task automatic start_link(input logic skip);
    if (!skip) send_frame(8'h1c, 1'b1);
  endtask
endmodule

// [test/deframer_lane_sync_status_ctrl_tb.sv]
// Self-checking bench for the deframer register slice.
`timescale 1ns/1ns
module deframer_lane_sync_status_ctrl_tb;
  localparam logic [11:0] SYN = deframer_pkg::IDX_LANE_SYNC;
  localparam logic [11:0] CKS = deframer_pkg::IDX_CHECKSUM;
  localparam logic [11:0] CT0 = deframer_pkg::IDX_CTRL0;
  localparam logic [11:0] CT1 = deframer_pkg::IDX_CTRL1;
  localparam logic [11:0] STA = deframer_pkg::IDX_IRQ_STATUS;
  localparam logic [11:0] MSK = deframer_pkg::IDX_IRQ_MASK;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, single_lane_mode, pready, pslverr, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  lane_alignment_synced, lane_checksum_ok, lane0_octet, out_octet;
  logic lane0_valid, lane0_is_ctrl, lane0_frame_end, lane0_multiframe_end;
  logic out_valid, out_is_ctrl, rx_enable, deframer_soft_reset, force_sync_request;
  logic frame_error_replace_enable, alignment_seq_expected, irq;
  logic [8:0]  outq [$];
  logic [11:0] ix [6] = '{CT0, CT1, SYN, CKS, STA, MSK};
  logic [7:0]  rv [6] = '{deframer_pkg::CTRL0_RESET, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int n_fail = 0;
  int checks_done = 0;
  integer seed = 32'hf78e;
  deframer_lane_sync_status_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .lane_alignment_synced, .lane_checksum_ok,
    .single_lane_mode, .lane0_valid, .lane0_octet, .lane0_is_ctrl, .lane0_frame_end,
    .lane0_multiframe_end, .out_valid, .out_octet, .out_is_ctrl, .rx_enable,
    .deframer_soft_reset, .force_sync_request, .frame_error_replace_enable,
    .alignment_seq_expected, .irq);
  lane_tx_model tx (.pclk, .lane0_valid, .lane0_octet, .lane0_is_ctrl, .lane0_frame_end,
    .lane0_multiframe_end, .lane_alignment_synced, .lane_checksum_ok);
  always #5 pclk = ~pclk;
  // Every octet leaving the block is queued.
  always @(posedge pclk) if (out_valid === 1'b1) outq.push_back({out_is_ctrl, out_octet});
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // Expected octet; a substituted closing character repeats the zero left by the soft reset.
  function automatic logic [8:0] exp_out(input logic [7:0] b, input int i, input logic keep);
    if (i < 3) return {1'b0, b + 8'(i)};
    return keep ? {1'b1, deframer_pkg::FRAME_END_CHAR} : 9'h000;
  endfunction
  task automatic frames(input logic en, input logic keep);
    logic [7:0] b;
    // Octets of an earlier frame drain before the queue is counted.
    repeat (2) @(posedge pclk);
    for (int f = 0; f < 3; f++) begin
      b = 8'($random(seed)) & 8'h3f;
      outq.delete();
      tx.send_frame(b, 1'b0);
      repeat (2) @(posedge pclk);
      chk(32'(outq.size()), en ? 32'h4 : 32'h0);
      foreach (outq[i]) chk(32'(outq[i]), 32'(exp_out(b, i, keep)));
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The watchdog ends a hung run as a failure.
  initial begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] s;
    logic [7:0] c;
    {psel, penable, pwrite, paddr, pwdata, single_lane_mode} = '0;
    pstrb = 4'hf;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state of outputs and registers, then an unmapped index.
    chk(32'({rx_enable, deframer_soft_reset, force_sync_request, frame_error_replace_enable,
      alignment_seq_expected, irq}), 32'h26);
    for (int i = 0; i < 6; i++) rdchk(ix[i], 32'(rv[i]));
    apb(1'b0, 12'h474, 32'h0);
    chk(32'(err), 32'h1);
    $display("test reset done");
    // Random lane flags read back, writes to the sync register ignored.
    for (int k = 0; k < 4; k++) begin
      s = 8'($random(seed));
      c = 8'($random(seed));
      tx.set_lanes(s, c);
      repeat (3) @(posedge pclk);
      rdchk(SYN, 32'(s));
      apb(1'b0, CKS, 32'h0);
      chk(32'(rd[0]), 32'(c[0]));
      apb(1'b1, SYN, 32'(~s));
      rdchk(SYN, 32'(s));
    end
    $display("test flags done");
    // Loss of sync raises a masked interrupt, cleared by writing one.
    tx.set_lanes(8'hff, 8'hff);
    apb(1'b1, MSK, 32'h1);
    apb(1'b1, STA, 32'hff);
    tx.set_lanes(8'hfc, 8'hff);
    repeat (4) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rdchk(STA, 32'h3);
    apb(1'b1, STA, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    rdchk(STA, 32'h2);
    $display("test irq done");
    // Soft reset, receiver disable changed only under it.
    apb(1'b1, CT0, 32'h09);
    chk(32'({rx_enable, deframer_soft_reset}), 32'h1);
    rdchk(SYN, 32'h0);
    apb(1'b1, CT0, 32'h8d);
    rdchk(CT0, 32'h8d);
    apb(1'b1, CT0, 32'h81);
    chk(32'({rx_enable, force_sync_request}), 32'h0);
    frames(1'b0, 1'b1);
    apb(1'b1, CT0, 32'h89);
    apb(1'b1, CT0, 32'h49);
    apb(1'b1, CT0, 32'h41);
    chk(32'(rx_enable), 32'h1);
    tx.start_link(1'b0);
    frames(1'b1, 1'b1);
    apb(1'b1, CT0, 32'h49);
    apb(1'b1, CT0, 32'h09);
    apb(1'b1, CT0, 32'h01);
    frames(1'b1, 1'b0);
    $display("test receive done");
    // Alignment expectation over every skip and lane-count pair.
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CT0, 32'h09);
      apb(1'b1, CT1, 32'(m[0]) << 1);
      single_lane_mode <= m[1];
      apb(1'b1, CT0, 32'h01);
      repeat (2) @(posedge pclk);
      chk(32'(alignment_seq_expected), 32'(!(m[0] && m[1])));
      // The link start frame is sent only when not skipping.
      tx.start_link(m[0] && m[1]);
    end
    $display("test align done");
    tally_and_finish();
  end
endmodule
